// File: core/srst_pkg.sv
// Shared constants, types and helpers of the system reset controller
package srst_pkg;

   // ***********************************************************
   // Register map (byte addresses) and field layout
   // ***********************************************************
   localparam logic [15:0] SRST_CAUSE_OFS = 16'hf00c;
   localparam logic [15:0] SRST_WDT_CTRL_OFS = 16'hf010;
   localparam logic [15:0] SRST_WDT_KICK_OFS = 16'hf014;
   localparam logic [15:0] SRST_INT_STAT_OFS = 16'hf018;
   localparam logic [15:0] SRST_INT_MASK_OFS = 16'hf01c;
   localparam int unsigned SRST_CAUSE_PIN_BIT = 6;
   localparam int unsigned SRST_CAUSE_LLD_BIT = 4;
   localparam int unsigned SRST_CAUSE_WDT_BIT = 2;
   localparam int unsigned SRST_CAUSE_POR_BIT = 0;
   localparam logic [7:0] SRST_CAUSE_RW_MASK = 8'h55;
   localparam logic [7:0] SRST_CAUSE_POR_VAL = 8'h01;
   localparam int unsigned SRST_WDT_SEL_LSB = 0;
   localparam int unsigned SRST_WDT_EN_BIT = 4;
   localparam logic [7:0] SRST_WDT_KICK_KEY = 8'h5a;
   localparam int unsigned SRST_INT_WARN_BIT = 0;
   localparam int unsigned SRST_INT_BRK_BIT = 1;
   localparam int unsigned SRST_INT_W = 2;

   // ***********************************************************
   // Vector words and timing
   // ***********************************************************
   localparam logic [15:0] SRST_SP_VEC = 16'h0000;
   localparam logic [15:0] SRST_PC_VEC = 16'h0002;
   localparam logic [15:0] SRST_PC_BRK_VEC = 16'h0004;
   localparam logic [1:0] SRST_BRK_ALT_LEVEL = 2'h1;
   localparam int unsigned SRST_CLK_PERIOD_NS = 10;
   localparam int unsigned SRST_WDT_BASE_MS = 125;
   localparam int unsigned SRST_WDT_BASE_CYCLES =
      SRST_WDT_BASE_MS * (1000000 / SRST_CLK_PERIOD_NS);
   localparam int unsigned SRST_HOLD_NS = 160;
   localparam int unsigned SRST_HOLD_CYCLES =
      (SRST_HOLD_NS + SRST_CLK_PERIOD_NS - 1) / SRST_CLK_PERIOD_NS;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef enum logic [1:0] {
      SRST_ST_HOLD = 2'h0,
      SRST_ST_FETCH = 2'h1,
      SRST_ST_RUN = 2'h3
   } srst_state_t;

   typedef enum logic [2:0] {
      SRST_SEL_NONE, SRST_SEL_CAUSE, SRST_SEL_WCTRL,
      SRST_SEL_KICK, SRST_SEL_ISTAT, SRST_SEL_IMASK
   } srst_sel_t;

   typedef struct packed {
      logic valid;
      logic write;
      srst_sel_t sel;
   } srst_ahb_req_t;

   typedef struct packed {
      logic en;
      logic [1:0] sel;
   } srst_wdt_cfg_t;

   // Watchdog period in base ticks: 1, 4, 16 or 64 times the base
   function automatic logic [7:0] srst_wdt_ticks(input logic [1:0] sel);
      return 8'h01 << {sel, 1'b0};
   endfunction

endpackage

// File: core/srst_wdt.sv
// Watchdog timer with four selectable overflow periods
`timescale 1ns/1ns
`default_nettype none
module srst_wdt
   import srst_pkg::*;
#(
   parameter int unsigned BASE_CYCLES = SRST_WDT_BASE_CYCLES
)
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Control
   input wire logic clr,
   input wire srst_wdt_cfg_t cfg,
   // Events
   output logic overflow,
   output logic warn
);

   localparam int unsigned CW = (BASE_CYCLES > 2) ? $clog2(BASE_CYCLES) : 1;
   localparam logic [CW-1:0] BASE_LAST = CW'(BASE_CYCLES - 1);

   initial
   begin
      if (BASE_CYCLES < 2)
         $error("srst_wdt: BASE_CYCLES must be at least 2");
   end

   logic [CW-1:0] div_ff;
   logic [7:0] ticks_ff;
   logic tick;
   logic [7:0] limit;

   assign tick = (div_ff == BASE_LAST);
   assign limit = srst_wdt_ticks(cfg.sel);
   // Overflow at the last base tick of the period
   assign overflow = cfg.en && tick && (ticks_ff == limit - 8'h01);
   // Halfway warning; the shortest period has none
   assign warn = cfg.en && tick && (ticks_ff + 8'h01 == (limit >> 1));

   // Base divider, one enable pulse per base period
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         div_ff <= '0;
      else if (clr || !cfg.en || tick)
         div_ff <= '0;
      else
         div_ff <= div_ff + CW'(1);
   end

   // Period counter in base ticks
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ticks_ff <= 8'h00;
      else if (clr || !cfg.en || overflow)
         ticks_ff <= 8'h00;
      else if (tick)
         ticks_ff <= ticks_ff + 8'h01;
   end

endmodule
`default_nettype wire

// File: core/srst_vec_fetch.sv
// Reads the stack pointer and program counter vectors from program memory
`timescale 1ns/1ns
`default_nettype none
module srst_vec_fetch
   import srst_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Control
   input wire logic start,
   input wire logic abort,
   input wire logic use_brk_vec,
   output logic done,
   // Program memory byte port
   output logic pm_req,
   output logic [15:0] pm_addr,
   input wire logic [7:0] pm_rdata,
   input wire logic pm_ack,
   // Loaded vectors
   output logic [15:0] sp,
   output logic [15:0] pc
);

   logic busy_ff;
   logic [1:0] idx_ff;
   logic [15:0] pc_base_ff;

   assign pm_req = busy_ff;
   assign done = busy_ff && pm_ack && (idx_ff == 2'h3);

   // Byte sequencer: SP low, SP high, PC low, PC high
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         busy_ff <= 1'b0;
         idx_ff <= 2'h0;
         pm_addr <= SRST_SP_VEC;
         pc_base_ff <= SRST_PC_VEC;
      end
      else if (abort || start)
      begin
         busy_ff <= start && !abort;
         idx_ff <= 2'h0;
         pm_addr <= SRST_SP_VEC;
         // Break with a low level takes the alternate vector
         pc_base_ff <= use_brk_vec ? SRST_PC_BRK_VEC : SRST_PC_VEC;
      end
      else if (busy_ff && pm_ack)
      begin
         busy_ff <= (idx_ff != 2'h3);
         idx_ff <= idx_ff + 2'h1;
         pm_addr <= (idx_ff == 2'h0) ? SRST_SP_VEC + 16'h0001 :
                    (idx_ff == 2'h1) ? pc_base_ff : pc_base_ff + 16'h0001;
      end
   end

   // Little-endian assembly of the two vectors
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sp <= 16'h0000;
         pc <= 16'h0000;
      end
      else if (busy_ff && pm_ack)
      begin
         unique case (idx_ff)
            2'h0: sp[7:0] <= pm_rdata;
            2'h1: sp[15:8] <= pm_rdata;
            2'h2: pc[7:0] <= pm_rdata;
            2'h3: pc[15:8] <= pm_rdata;
         endcase
      end
   end

endmodule
`default_nettype wire

// File: core/srst_top.sv
// System reset controller: source merge, cause register, CPU vector load
//
// Functional notes
// - Any of pin, power-on, watchdog, low-level or break enters reset.
// - The watchdog offers 125 ms, 500 ms, 2 s and 8 s periods.
// - A break reset resets only the CPU, not RAM nor the registers.
// - Reset keeps the cause register except the current cause flag.
// - A pin reset sets the pin flag at bit 6.
// - A low-level reset sets bit 4; its power-up value is undefined (power-up clears it here).
// - A watchdog overflow reset sets bit 2.
// - Power-up sets bit 0, which then reads one.
// - Reset overrides all activity and abandons work in progress.
// - The power circuit is initialised on every reset except break.
// - Registers with defined reset values load them, except on break.
// - Every reset initialises the CPU and loads SP from 0000H/0001H.
// - PC comes from 0002H/0003H, or 0004H/0005H after a low-level break.
// - Data memory and undefined-value registers are not initialised.
`timescale 1ns/1ns
`default_nettype none
module srst_top
   import srst_pkg::*;
#(
   parameter int unsigned WDT_BASE_CYCLES = SRST_WDT_BASE_CYCLES,
   parameter int unsigned HOLD_CYCLES = SRST_HOLD_CYCLES
)
(
   // Clock and power-on reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Reset sources
   input wire logic reset_pin_n,
   input wire logic low_level_detector,
   input wire logic software_break_instr,
   input wire logic [1:0] interrupt_level_field,
   // Reset mode outputs
   output logic sys_reset_mode,
   output logic power_init,
   output logic sfr_init,
   output logic cpu_init,
   output logic cpu_start,
   output logic [15:0] cpu_sp,
   output logic [15:0] cpu_pc,
   // Program memory byte port
   output logic pm_req,
   output logic [15:0] pm_addr,
   input wire logic [7:0] pm_rdata,
   input wire logic pm_ack,
   // Interrupt
   output logic irq
);

   localparam int unsigned HW = (HOLD_CYCLES > 1) ? $clog2(HOLD_CYCLES) : 1;
   localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);

   initial
   begin
      if (HOLD_CYCLES < 1)
         $error("srst_top: HOLD_CYCLES must be at least 1");
   end

   // ***********************************************************
   // Declarations and address decode
   // ***********************************************************
   function automatic srst_sel_t srst_decode(input logic [31:0] a);
      srst_sel_t s;
      s = SRST_SEL_NONE;
      if (a[31:16] == 16'h0000)
      begin
         unique case (a[15:0])
            SRST_CAUSE_OFS: s = SRST_SEL_CAUSE;
            SRST_WDT_CTRL_OFS: s = SRST_SEL_WCTRL;
            SRST_WDT_KICK_OFS: s = SRST_SEL_KICK;
            SRST_INT_STAT_OFS: s = SRST_SEL_ISTAT;
            SRST_INT_MASK_OFS: s = SRST_SEL_IMASK;
            default: s = SRST_SEL_NONE;
         endcase
      end
      return s;
   endfunction

   logic pin_sync1_ff;
   logic pin_sync2_ff;
   srst_ahb_req_t ap_ff;
   srst_state_t state_ff;
   srst_state_t nxt_state;
   logic [HW-1:0] hold_ff;
   logic full_ff;
   logic brk_alt_ff;
   logic [7:0] cause_ff;
   logic [7:0] nxt_cause;
   srst_wdt_cfg_t wdt_cfg_ff;
   logic [SRST_INT_W-1:0] int_stat_ff;
   logic [SRST_INT_W-1:0] int_mask_ff;
   logic pin_req;
   logic wdt_ovf;
   logic wdt_warn;
   logic full_req;
   logic brk_req;
   logic any_req;
   logic fetch_done;
   logic sfr_clr;
   logic wr_en;
   logic [7:0] wbyte;
   logic [SRST_INT_W-1:0] int_events;

   // ***********************************************************
   // Reset source merge
   // ***********************************************************
   // Pin is asynchronous; two flops before any use
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_sync1_ff <= 1'b1;
         pin_sync2_ff <= 1'b1;
      end
      else
      begin
         pin_sync1_ff <= reset_pin_n;
         pin_sync2_ff <= pin_sync1_ff;
      end
   end

   assign pin_req = !pin_sync2_ff;
   // Full sources: the power-on itself is the async reset
   assign full_req = pin_req || low_level_detector || wdt_ovf;
   // A break can only come from a running CPU
   assign brk_req = software_break_instr && (state_ff == SRST_ST_RUN);
   assign any_req = full_req || brk_req;

   // ***********************************************************
   // Reset mode sequencer
   // ***********************************************************
   // Any request restarts the hold, whatever was going on
   always_comb
   begin
      nxt_state = state_ff;
      if (any_req)
         nxt_state = SRST_ST_HOLD;
      else
      begin
         unique case (state_ff)
            SRST_ST_HOLD:
               if (hold_ff == HOLD_LAST)
                  nxt_state = SRST_ST_FETCH;
            SRST_ST_FETCH:
               if (fetch_done)
                  nxt_state = SRST_ST_RUN;
            SRST_ST_RUN:
               nxt_state = SRST_ST_RUN;
            default:
               nxt_state = SRST_ST_HOLD;
         endcase
      end
   end

   // State register; power-on starts in a full hold
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state_ff <= SRST_ST_HOLD;
      else
         state_ff <= nxt_state;
   end

   // Hold counter, reloaded by each new request
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hold_ff <= '0;
      else if (any_req || state_ff != SRST_ST_HOLD)
         hold_ff <= '0;
      else if (hold_ff != HOLD_LAST)
         hold_ff <= hold_ff + HW'(1);
   end

   // Reset kind: a full source always outranks a break
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         full_ff <= 1'b1;
         brk_alt_ff <= 1'b0;
      end
      else if (full_req)
      begin
         full_ff <= 1'b1;
         brk_alt_ff <= 1'b0;
      end
      else if (brk_req)
      begin
         full_ff <= 1'b0;
         brk_alt_ff <= (interrupt_level_field <= SRST_BRK_ALT_LEVEL);
      end
   end

   // Init strobes; a break only touches the CPU
   assign sys_reset_mode = (state_ff != SRST_ST_RUN);
   assign cpu_init = (state_ff == SRST_ST_HOLD);
   assign power_init = cpu_init && full_ff;
   assign sfr_init = cpu_init && full_ff;
   assign sfr_clr = sfr_init;
   assign cpu_start = fetch_done && !any_req;

   // Vector fetch starts as the hold ends
   srst_vec_fetch u_fetch (
      .hclk (hclk),
      .hresetn (hresetn),
      .start (state_ff == SRST_ST_HOLD && nxt_state == SRST_ST_FETCH),
      .abort (any_req),
      .use_brk_vec (brk_alt_ff),
      .done (fetch_done),
      .pm_req (pm_req),
      .pm_addr (pm_addr),
      .pm_rdata (pm_rdata),
      .pm_ack (pm_ack),
      .sp (cpu_sp),
      .pc (cpu_pc)
   );

   // ***********************************************************
   // Watchdog
   // ***********************************************************
   srst_wdt #(
      .BASE_CYCLES (WDT_BASE_CYCLES)
   ) u_wdt (
      .hclk (hclk),
      .hresetn (hresetn),
      .clr (sfr_clr || (wr_en && ap_ff.sel == SRST_SEL_KICK &&
                        wbyte == SRST_WDT_KICK_KEY)),
      .cfg (wdt_cfg_ff),
      .overflow (wdt_ovf),
      .warn (wdt_warn)
   );

   // ***********************************************************
   // AHB-Lite slave
   // ***********************************************************
   // Zero wait state, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ap_ff <= '0;
      else if (hready)
      begin
         ap_ff.valid <= hsel && htrans[1];
         ap_ff.write <= hwrite;
         ap_ff.sel <= srst_decode(haddr);
      end
   end

   assign wr_en = ap_ff.valid && ap_ff.write;
   assign wbyte = hwdata[7:0];

   // Read mux in the data phase, so a read right after a write sees it
   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (ap_ff.valid && !ap_ff.write)
      begin
         unique case (ap_ff.sel)
            SRST_SEL_CAUSE:
               hrdata[7:0] = cause_ff & SRST_CAUSE_RW_MASK;
            SRST_SEL_WCTRL:
            begin
               hrdata[SRST_WDT_EN_BIT] = wdt_cfg_ff.en;
               hrdata[SRST_WDT_SEL_LSB +: 2] = wdt_cfg_ff.sel;
            end
            SRST_SEL_ISTAT:
               hrdata[SRST_INT_W-1:0] = int_stat_ff;
            SRST_SEL_IMASK:
               hrdata[SRST_INT_W-1:0] = int_mask_ff;
            default:
               hrdata = 32'h0000_0000;
         endcase
      end
   end

   // ***********************************************************
   // Reset cause register
   // ***********************************************************
   // Not touched by system reset; new causes win over a clearing write
   always_comb
   begin
      nxt_cause = cause_ff;
      if (wr_en && ap_ff.sel == SRST_SEL_CAUSE)
         nxt_cause = wbyte & SRST_CAUSE_RW_MASK;
      if (pin_req)
         nxt_cause[SRST_CAUSE_PIN_BIT] = 1'b1;
      if (low_level_detector)
         nxt_cause[SRST_CAUSE_LLD_BIT] = 1'b1;
      if (wdt_ovf)
         nxt_cause[SRST_CAUSE_WDT_BIT] = 1'b1;
   end

   // Power-up leaves only the power-on flag set
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cause_ff <= SRST_CAUSE_POR_VAL;
      else
         cause_ff <= nxt_cause & SRST_CAUSE_RW_MASK;
   end

   // ***********************************************************
   // Control registers and interrupt
   // ***********************************************************
   // Watchdog control, initialised on full resets only
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wdt_cfg_ff <= '0;
      else if (sfr_clr)
         wdt_cfg_ff <= '0;
      else if (wr_en && ap_ff.sel == SRST_SEL_WCTRL)
      begin
         wdt_cfg_ff.en <= wbyte[SRST_WDT_EN_BIT];
         wdt_cfg_ff.sel <= wbyte[SRST_WDT_SEL_LSB +: 2];
      end
   end

   assign int_events[SRST_INT_WARN_BIT] = wdt_warn;
   assign int_events[SRST_INT_BRK_BIT] = cpu_start && !full_ff;

   // Sticky status, write one to clear; set beats clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         int_stat_ff <= '0;
      else if (sfr_clr)
         int_stat_ff <= '0;
      else if (wr_en && ap_ff.sel == SRST_SEL_ISTAT)
         int_stat_ff <= (int_stat_ff & ~wbyte[SRST_INT_W-1:0]) | int_events;
      else
         int_stat_ff <= int_stat_ff | int_events;
   end

   // Interrupt mask, one enables a status bit
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         int_mask_ff <= '0;
      else if (sfr_clr)
         int_mask_ff <= '0;
      else if (wr_en && ap_ff.sel == SRST_SEL_IMASK)
         int_mask_ff <= wbyte[SRST_INT_W-1:0];
   end

   // Level interrupt; hsize is not checked, word access is assumed
   assign irq = |(int_stat_ff & int_mask_ff);

endmodule
`default_nettype wire

// File: bench/srst_pm_model.sv
// Program memory model answering vector byte reads
`timescale 1ns/1ns
`default_nettype none
module srst_pm_model
(
   // Clock
   input wire logic hclk,
   // Answer delay in cycles
   input wire logic [3:0] lat,
   // Program memory byte port
   input wire logic pm_req,
   input wire logic [15:0] pm_addr,
   output logic [7:0] pm_rdata,
   output logic pm_ack
);
   logic [3:0] wait_cnt = 4'h0;
   logic [7:0] last = 8'h00;

   // Byte k holds 8'h10 + k; data floats to the inverse when idle
   always @(posedge hclk)
   begin
      pm_ack <= 1'b0;
      pm_rdata <= ~last;
      if (!pm_req || pm_ack)
         wait_cnt <= 4'h0;
      else if (wait_cnt < lat)
         wait_cnt <= wait_cnt + 4'h1;
      else
      begin
         pm_ack <= 1'b1;
         pm_rdata <= 8'h10 + pm_addr[7:0];
         last <= 8'h10 + pm_addr[7:0];
      end
   end
endmodule
`default_nettype wire

// File: bench/srst_top_assertions.sv
// Checker of reset entry, vector fetch order and release
`timescale 1ns/1ns
`default_nettype none
module srst_top_assertions
   import srst_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Reset sources
   input wire logic reset_pin_n,
   input wire logic low_level_detector,
   input wire logic software_break_instr,
   // Reset mode and vector fetch
   input wire logic sys_reset_mode,
   input wire logic power_init,
   input wire logic sfr_init,
   input wire logic cpu_init,
   input wire logic cpu_start,
   input wire logic pm_req,
   input wire logic [15:0] pm_addr,
   input wire logic pm_ack
);
   // ********
   // Sequences
   // ********
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Pin held long enough to pass the synchroniser
   sequence s_pin_low;
      !reset_pin_n [*4];
   endsequence
   // Break only counts while running
   sequence s_brk;
      software_break_instr && !sys_reset_mode;
   endsequence
   // Last vector byte handed over
   sequence s_pc_hi;
      pm_req && pm_ack && (pm_addr == SRST_PC_VEC + 16'h1 ||
         pm_addr == SRST_PC_BRK_VEC + 16'h1);
   endsequence

   // ********
   // Assertions
   // ********
   pin_entry_a: assert property (
      s_pin_low |-> sys_reset_mode && power_init && sfr_init)
      else $error("pin reset not entered");
   lld_entry_a: assert property (
      low_level_detector |-> ##[1:2] (sys_reset_mode && power_init))
      else $error("low-level reset not entered");
   brk_cpu_only_a: assert property (
      s_brk |=> sys_reset_mode && cpu_init && !power_init && !sfr_init)
      else $error("break reset touched more than the cpu");
   fetch_first_a: assert property (
      $rose(pm_req) |-> pm_addr == SRST_SP_VEC && !cpu_init)
      else $error("fetch not started at stack vector");
   sp_order_a: assert property (
      pm_req && pm_ack && pm_addr == SRST_SP_VEC |=>
         pm_req && pm_addr == SRST_SP_VEC + 16'h1)
      else $error("stack vector high byte not next");
   start_last_a: assert property (
      cpu_start |-> s_pc_hi)
      else $error("cpu started before pc vector done");
   release_a: assert property (
      $fell(sys_reset_mode) |-> $past(cpu_start))
      else $error("reset left without vector load");
   abort_a: assert property (
      low_level_detector && pm_req |-> ##[1:2] !pm_req)
      else $error("fetch not abandoned on new reset");
endmodule

bind srst_top srst_top_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
   .reset_pin_n(reset_pin_n), .low_level_detector(low_level_detector),
   .software_break_instr(software_break_instr),
   .sys_reset_mode(sys_reset_mode), .power_init(power_init),
   .sfr_init(sfr_init), .cpu_init(cpu_init), .cpu_start(cpu_start),
   .pm_req(pm_req), .pm_addr(pm_addr), .pm_ack(pm_ack));
`default_nettype wire

// File: bench/srst_top_test.sv
// Self-checking bench of the system reset controller
`timescale 1ns/1ns
`default_nettype none
module srst_top_test
   import srst_pkg::*;
   ;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic pin_n = 1'b1;
   logic lld_req = 1'b0;
   logic brk_req = 1'b0;
   logic [1:0] lvl = 2'h0;
   logic [3:0] lat = 4'h0;
   logic hready, hreadyout, hresp, sys_reset_mode, power_init, sfr_init;
   logic cpu_init, cpu_start, pm_req, pm_ack, irq;
   logic [31:0] hrdata;
   logic [15:0] cpu_sp, cpu_pc, pm_addr;
   logic [7:0] pm_rdata;
   int num_errors = 0;
   int num_checks = 0;

   // Single slave: its ready is the bus ready
   assign hready = hreadyout;

   // Short counts keep the run brief
   srst_top #(.WDT_BASE_CYCLES(8), .HOLD_CYCLES(2)) DUT (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .reset_pin_n(pin_n), .low_level_detector(lld_req),
      .software_break_instr(brk_req), .interrupt_level_field(lvl),
      .sys_reset_mode(sys_reset_mode), .power_init(power_init),
      .sfr_init(sfr_init), .cpu_init(cpu_init), .cpu_start(cpu_start),
      .cpu_sp(cpu_sp), .cpu_pc(cpu_pc), .pm_req(pm_req), .pm_addr(pm_addr),
      .pm_rdata(pm_rdata), .pm_ack(pm_ack), .irq(irq));

   srst_pm_model u_pm (.hclk(hclk), .lat(lat), .pm_req(pm_req),
      .pm_addr(pm_addr), .pm_rdata(pm_rdata), .pm_ack(pm_ack));

   // ********
   // Tasks
   // ********
   initial forever #5 hclk = ~hclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One single AHB transfer, address phase then data phase
   task automatic bus(input logic w, input logic [15:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {16'h0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask

   // Let the last write land before looking at the level output
   task automatic chk_irq(input logic exp);
      #1;
      chk({31'h0, irq}, {31'h0, exp});
   endtask

   task automatic wait_run();
      repeat (3) @(posedge hclk);
      for (int i = 0; i < 100 && sys_reset_mode !== 1'b0; i++)
         @(posedge hclk);
   endtask

   // Vector bytes of the model: SP 1110, PC 1312, alternate PC 1514
   task automatic vec(input logic [15:0] pc);
      chk({16'h0, cpu_sp}, 32'h1110);
      chk({16'h0, cpu_pc}, {16'h0, pc});
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Hang guard, well beyond the longest watchdog period
   initial
   begin
      repeat (5000) @(posedge hclk);
      num_errors++;
      close_out();
   end

   // ********
   // Tests
   // ********
   initial
   begin
      int n;
      int p;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      wait_run();
      vec(16'h1312);
      rd(SRST_CAUSE_OFS, 32'h01);
      wr(SRST_CAUSE_OFS, 32'hff);
      rd(SRST_CAUSE_OFS, 32'h55);
      wr(SRST_CAUSE_OFS, 32'h00);
      rd(16'hf008, 32'h0);
      $display("test power-up done");
      pin_n <= 1'b0;
      repeat (4) @(posedge hclk);
      pin_n <= 1'b1;
      wait_run();
      rd(SRST_CAUSE_OFS, 32'h40);
      // Slow memory, then a second request in mid-fetch
      lat <= 4'h5;
      lld_req <= 1'b1;
      @(posedge hclk);
      lld_req <= 1'b0;
      for (int i = 0; i < 50 && pm_req !== 1'b1; i++)
         @(posedge hclk);
      lld_req <= 1'b1;
      @(posedge hclk);
      lld_req <= 1'b0;
      lat <= 4'h0;
      wait_run();
      vec(16'h1312);
      rd(SRST_CAUSE_OFS, 32'h50);
      $display("test pin and low-level done");
      wr(SRST_CAUSE_OFS, 32'h00);
      for (int s = 0; s < 4; s++)
      begin
         p = 8 << (2 * s);
         wr(SRST_WDT_CTRL_OFS, 32'h10 | 32'(s));
         n = 0;
         while (sys_reset_mode !== 1'b1 && n < 1000)
         begin
            @(posedge hclk);
            n++;
         end
         chk(32'(n >= p - 1 && n <= p + 4), 32'h1);
         wait_run();
         rd(SRST_CAUSE_OFS, 32'h04);
         rd(SRST_WDT_CTRL_OFS, 32'h00);
      end
      $display("test watchdog done");
      wr(SRST_WDT_CTRL_OFS, 32'h11);
      repeat (20) @(posedge hclk);
      // Kick before the 32-cycle overflow; no reset may follow
      wr(SRST_WDT_KICK_OFS, {24'h0, SRST_WDT_KICK_KEY});
      repeat (20) @(posedge hclk);
      chk({31'h0, sys_reset_mode}, 32'h0);
      wr(SRST_WDT_CTRL_OFS, 32'h00);
      rd(SRST_INT_STAT_OFS, 32'h01);
      chk_irq(1'b0);
      wr(SRST_INT_MASK_OFS, 32'h01);
      chk_irq(1'b1);
      wr(SRST_INT_STAT_OFS, 32'h01);
      chk_irq(1'b0);
      $display("test interrupt done");
      wr(SRST_INT_MASK_OFS, 32'h02);
      for (int l = 0; l < 4; l++)
      begin
         @(posedge hclk);
         brk_req <= 1'b1;
         lvl <= 2'(l);
         @(posedge hclk);
         brk_req <= 1'b0;
         wait_run();
         vec(l <= 1 ? 16'h1514 : 16'h1312);
      end
      rd(SRST_CAUSE_OFS, 32'h04);
      rd(SRST_INT_MASK_OFS, 32'h02);
      rd(SRST_INT_STAT_OFS, 32'h02);
      chk_irq(1'b1);
      wr(SRST_INT_STAT_OFS, 32'h02);
      chk_irq(1'b0);
      $display("test break done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      wait_run();
      rd(SRST_CAUSE_OFS, 32'h01);
      rd(SRST_INT_MASK_OFS, 32'h00);
      $display("test second power-up done");
      close_out();
   end
endmodule
`default_nettype wire
